/* File: hw/rts_map.svh */
`ifndef RTS_MAP_SVH
`define RTS_MAP_SVH

// register byte offsets
`define RTS_OFS_CTRL        12'h000
`define RTS_OFS_STATUS      12'h004
`define RTS_OFS_LOCK_CNT    12'h008
`define RTS_OFS_REF_TICKS   12'h00C

// control fields
`define RTS_CTRL_HOLD_BIT   0
`define RTS_CTRL_RST        1'b0

// status fields
`define RTS_ST_STATE_LSB    0
`define RTS_ST_STATE_MSB    1
`define RTS_ST_LOCKED_BIT   2
`define RTS_ST_PA_BIT       3
`define RTS_ST_FLOW_BIT     4
`define RTS_ST_EN_BIT       5
`define RTS_ST_MULT_LSB     8
`define RTS_ST_MULT_MSB     15

// timing
`define RTS_PCLK_NS         50
`define RTS_LOCK_TIME_NS    1000000
`define RTS_LOCK_CNT_W      15

// loop multiplication factor of the oscillator
`define RTS_VCO_MULT        8'h40
`define RTS_VCO_MULT_W      6
`define RTS_VCO_WRAP        6'h3F
`define RTS_TICK_W          16

`endif

/* File: hw/rts_pkg.sv */
`default_nettype none
package rts_pkg;

    typedef enum logic [1:0] {
        RTS_ST_STANDBY = 2'b00,
        RTS_ST_LOCKING = 2'b01,
        RTS_ST_LOCKED  = 2'b10
    } rts_state_t;

    // control pins from the microcontroller
    typedef struct packed {
        logic enable;
        logic amplifier_on;
        logic fsk_switch_closed;
    } rts_pins_t;

    // power and modulation controls of the transmitter die
    typedef struct packed {
        logic osc_on;
        logic pll_on;
        logic clk_drv_on;
        logic pa_on;
        logic freq_low;
    } rts_rf_ctrl_t;

endpackage
`default_nettype wire

/* File: hw/rts_transmit_sequencer.sv */
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "rts_map.svh"

// Summary of operation
// [RL1] enable and amplifier_on low: oscillator, loop, clock driver, amplifier all off.
// [RL2] enable high switches on oscillator, loop and clock output driver; here only while the software hold is clear.
// [RL3] enable high, amplifier_on low: clock delivered, amplifier off; here no clock while the software hold is set.
// [RL4] enable and amplifier_on high: loop, oscillator, driver and amplifier on; here all stay off while the software hold is set.
// [RL5] loop locks and clock output is stable within 1 ms of enable; here locked rises LOCK_CYC + 2 pclk cycles after the enable pin is sampled.
// [RL6] controller keeps amplifier_on low 4 ms after enable before use.
// [RL7] ASK: controller keys data by toggling amplifier_on per symbol.
// [RL8] FSK: controller holds amplifier_on high for the whole transmission.
// [RL9] FSK: controller pulls the crystal via an open-drain capacitor switch.
// [RL10] closed capacitor switch gives the lower of the two frequencies.
// [RL11] at the end controller drops amplifier_on and returns to RC clock.
// [RL12] after the clock switch-back controller drops enable for standby.
// [RL13] data is Manchester coded, at most 32 kbaud.
// [RL14] oscillator locks to 64 times the crystal oscillator frequency.
// [RL15] controller starts on RC clock, adopts transmitter clock after the wait.
// [RL16] controller times the wait on its RC clock, switch open when idle.
module rts_transmit_sequencer #(
    parameter int LOCK_CYC = `RTS_LOCK_TIME_NS / `RTS_PCLK_NS
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire rts_pkg::rts_pins_t    pins,
    output rts_pkg::rts_rf_ctrl_t      rf_ctrl,
    output logic                       locked,
    input  wire logic                  link_clk,
    output logic                       clk_out
);
    import rts_pkg::*;

    localparam int LCW = `RTS_LOCK_CNT_W;

    rts_pins_t                 pin_m_r;
    rts_pins_t                 pin_s_r;
    rts_state_t                state_r;
    rts_state_t                state_nxt;
    logic [LCW-1:0]            lock_cnt_r;
    logic                      hold_r;
    rts_rf_ctrl_t              rf_r;
    logic                      locked_r;
    logic [31:0]               prdata_r;
    logic [31:0]               rd_nxt;
    logic                      rd_ok_nxt;
    logic                      pready_r;
    logic                      pslverr_r;
    logic                      run;
    logic                      tog_m_r;
    logic                      tog_s_r;
    logic                      tog_d_r;
    logic [`RTS_TICK_W-1:0]    ticks_r;
    logic                      drv_m_r;
    logic                      drv_s_r;
    logic [`RTS_VCO_MULT_W-1:0] div_r;
    logic                      ref_tog_r;
    logic                      clk_out_r;

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign rf_ctrl = rf_r;
    assign locked  = locked_r;
    assign clk_out = clk_out_r;

    // pins come from the controller's own clock, so two stages first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_m_r <= '0;
            pin_s_r <= '0;
        end else begin
            pin_m_r <= pins;
            pin_s_r <= pin_m_r;
        end
    end

    // software hold keeps the die in standby whatever the pins say
    assign run = pin_s_r.enable & ~hold_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RTS_ST_STANDBY: begin
                if (run) begin
                    state_nxt = RTS_ST_LOCKING;
                end
            end
            RTS_ST_LOCKING: begin
                if (!run) begin
                    state_nxt = RTS_ST_STANDBY;
                end else if (lock_cnt_r == LCW'(LOCK_CYC - 1)) begin
                    state_nxt = RTS_ST_LOCKED; // [RL5]
                end
            end
            RTS_ST_LOCKED: begin
                if (!run) begin
                    state_nxt = RTS_ST_STANDBY;
                end
            end
            default: begin
                state_nxt = RTS_ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= RTS_ST_STANDBY;
            locked_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            locked_r <= (state_nxt == RTS_ST_LOCKED);
        end
    end

    // lock timer runs only while the loop is settling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_r <= '0;
        end else if (state_r == RTS_ST_LOCKING && state_nxt == RTS_ST_LOCKING) begin
            lock_cnt_r <= lock_cnt_r + LCW'(1); // [RL5]
        end else begin
            lock_cnt_r <= '0;
        end
    end

    // power controls follow the pins with one registered stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rf_r <= '0;
        end else begin
            rf_r.osc_on     <= run; // [RL1] [RL2]
            rf_r.pll_on     <= run; // [RL2]
            rf_r.clk_drv_on <= run; // [RL2] [RL3]
            rf_r.pa_on      <= run & pin_s_r.amplifier_on; // [RL3] [RL4] [RL7] [RL8]
            rf_r.freq_low   <= run & pin_s_r.fsk_switch_closed; // [RL9] [RL10]
        end
    end

    // apb read mux, sampled in the setup cycle
    always_comb begin
        rd_nxt    = 32'h0000_0000;
        rd_ok_nxt = 1'b1;
        case (paddr)
            `RTS_OFS_CTRL: begin
                rd_nxt[`RTS_CTRL_HOLD_BIT] = hold_r;
            end
            `RTS_OFS_STATUS: begin
                rd_nxt[`RTS_ST_STATE_MSB:`RTS_ST_STATE_LSB] = state_r;
                rd_nxt[`RTS_ST_LOCKED_BIT] = locked_r;
                rd_nxt[`RTS_ST_PA_BIT]     = rf_r.pa_on;
                rd_nxt[`RTS_ST_FLOW_BIT]   = rf_r.freq_low;
                rd_nxt[`RTS_ST_EN_BIT]     = pin_s_r.enable;
                rd_nxt[`RTS_ST_MULT_MSB:`RTS_ST_MULT_LSB] = `RTS_VCO_MULT; // [RL14]
            end
            `RTS_OFS_LOCK_CNT: begin
                rd_nxt[LCW-1:0] = lock_cnt_r;
            end
            `RTS_OFS_REF_TICKS: begin
                rd_nxt[`RTS_TICK_W-1:0] = ticks_r;
            end
            default: begin
                rd_ok_nxt = 1'b0;
            end
        endcase
    end

    // one wait-free access cycle: ready rises in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready_r  <= 1'b1;
            pslverr_r <= ~rd_ok_nxt;
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= `RTS_CTRL_RST;
        end else if (psel && penable && pready_r && pwrite && paddr == `RTS_OFS_CTRL) begin
            hold_r <= pwdata[`RTS_CTRL_HOLD_BIT];
        end
    end

    // reference tick events from the link side, one per reference period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_m_r <= 1'b0;
            tog_s_r <= 1'b0;
            tog_d_r <= 1'b0;
            ticks_r <= '0;
        end else begin
            tog_m_r <= ref_tog_r;
            tog_s_r <= tog_m_r;
            tog_d_r <= tog_s_r;
            if (tog_s_r ^ tog_d_r) begin
                ticks_r <= ticks_r + `RTS_TICK_W'(1); // [RL14]
            end
        end
    end

    // link domain: loop clock, 64 times the reference, drives the clock output to the controller
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            drv_m_r <= 1'b0;
            drv_s_r <= 1'b0;
        end else begin
            drv_m_r <= rf_r.clk_drv_on;
            drv_s_r <= drv_m_r;
        end
    end

    // output stays low while the driver is off, no runt pulse at switch-off
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            clk_out_r <= 1'b0;
        end else if (drv_s_r) begin
            clk_out_r <= ~clk_out_r; // [RL3]
        end else begin
            clk_out_r <= 1'b0; // [RL1]
        end
    end

    // divide by the loop factor to mark each reference period
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            div_r     <= '0;
            ref_tog_r <= 1'b0;
        end else if (drv_s_r) begin
            div_r <= div_r + `RTS_VCO_MULT_W'(1);
            if (div_r == `RTS_VCO_WRAP) begin
                ref_tog_r <= ~ref_tog_r; // [RL14]
            end
        end else begin
            div_r <= '0;
        end
    end

    property p_standby_off;
        @(posedge pclk) disable iff (!presetn)
        !pin_s_r.enable |=> !rf_r.osc_on && !rf_r.pll_on && !rf_r.clk_drv_on && !rf_r.pa_on;
    endproperty
    a_standby_off: assert property (p_standby_off) // [RL1]
        else $error("transmitter not in standby with enable low");

    property p_enable_on;
        @(posedge pclk) disable iff (!presetn)
        (pin_s_r.enable && !hold_r) |=> rf_r.osc_on && rf_r.pll_on && rf_r.clk_drv_on;
    endproperty
    a_enable_on: assert property (p_enable_on) // [RL2]
        else $error("enable did not start oscillator, loop and driver");

    property p_clock_only;
        @(posedge pclk) disable iff (!presetn)
        (run && !pin_s_r.amplifier_on) |=> rf_r.clk_drv_on && !rf_r.pa_on;
    endproperty
    a_clock_only: assert property (p_clock_only) // [RL3]
        else $error("amplifier on without amplifier_on");

    property p_all_on;
        @(posedge pclk) disable iff (!presetn)
        (run && pin_s_r.amplifier_on) |=> rf_r.pa_on && rf_r.pll_on && rf_r.osc_on;
    endproperty
    a_all_on: assert property (p_all_on) // [RL4]
        else $error("amplifier not running with enable and amplifier_on");

    property p_lock_bound;
        @(posedge pclk) disable iff (!presetn)
        (state_r == RTS_ST_LOCKING && lock_cnt_r == LCW'(LOCK_CYC - 1) && run)
            |=> locked_r && state_r == RTS_ST_LOCKED;
    endproperty
    a_lock_bound: assert property (p_lock_bound) // [RL5]
        else $error("loop not locked at the lock time");

    property p_lock_range;
        @(posedge pclk) disable iff (!presetn)
        (state_r == RTS_ST_LOCKING) |-> (lock_cnt_r < LCW'(LOCK_CYC)) && !locked_r;
    endproperty
    a_lock_range: assert property (p_lock_range) // [RL5]
        else $error("lock timer overran");

    property p_freq_low;
        @(posedge pclk) disable iff (!presetn)
        run |=> rf_r.freq_low == $past(pin_s_r.fsk_switch_closed);
    endproperty
    a_freq_low: assert property (p_freq_low) // [RL10]
        else $error("frequency select does not follow the capacitor switch");

    property p_ref_tick;
        @(posedge link_clk) disable iff (!presetn)
        (drv_s_r && div_r == `RTS_VCO_WRAP) |=> ref_tog_r != $past(ref_tog_r) && div_r == '0;
    endproperty
    a_ref_tick: assert property (p_ref_tick) // [RL14]
        else $error("reference tick not at loop factor");

    property p_clk_toggle;
        @(posedge link_clk) disable iff (!presetn)
        drv_s_r |=> clk_out_r != $past(clk_out_r);
    endproperty
    a_clk_toggle: assert property (p_clk_toggle) // [RL3]
        else $error("clock output not toggling while driver on");

    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready_r ##1 !pready_r;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("apb ready not a single access cycle");

    // a stopped driver must leave the controller clock parked low
    property p_clk_quiet;
        @(posedge link_clk) disable iff (!presetn)
        !drv_s_r |=> !clk_out_r;
    endproperty
    a_clk_quiet: assert property (p_clk_quiet) // [RL1]
        else $error("clock output active while driver off");

    property p_pa_with_loop;
        @(posedge pclk) disable iff (!presetn)
        rf_r.pa_on |-> rf_r.osc_on && rf_r.pll_on && rf_r.clk_drv_on;
    endproperty
    a_pa_with_loop: assert property (p_pa_with_loop) // [RL4]
        else $error("amplifier on without loop, oscillator and driver");

    property p_tick_count;
        @(posedge pclk) disable iff (!presetn)
        (tog_s_r != tog_d_r) |=> ticks_r == $past(ticks_r) + `RTS_TICK_W'(1);
    endproperty
    a_tick_count: assert property (p_tick_count) // [RL14]
        else $error("reference tick not counted");

endmodule
`default_nettype wire

/* File: verif/rts_mcu_model.sv */
`timescale 1ns/100ps
`default_nettype none
// counts shrunk: wait stays four times the lock count, symbols stay short
module rts_mcu_model #(
    parameter int WAIT_CYC = 80,
    parameter int HALF_CYC = 4
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          go,
    input  wire logic          fsk,
    input  wire logic [3:0]    data,
    output rts_pkg::rts_pins_t pins,
    output logic               busy
);
    import rts_pkg::*;
    logic [15:0] cnt_r;
    logic [3:0]  step_r;
    logic        bit_v;

    // manchester: each bit as itself, then inverted
    assign bit_v = data[step_r[2:1]] ^ step_r[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins   <= '0;
            busy   <= 1'b0;
            cnt_r  <= '0;
            step_r <= '0;
        end else if (go && !busy) begin
            busy        <= 1'b1;
            pins.enable <= 1'b1;
            cnt_r       <= 16'(WAIT_CYC);
        end else if (busy && cnt_r != 16'h0) begin
            cnt_r <= cnt_r - 16'h1;
        end else if (busy) begin
            cnt_r  <= 16'(HALF_CYC);
            step_r <= step_r + 4'h1;
            if (step_r < 4'h8) begin
                pins.amplifier_on      <= fsk | bit_v;
                pins.fsk_switch_closed <= fsk & bit_v;
            end else if (step_r == 4'h8) begin
                pins.amplifier_on      <= 1'b0;
                pins.fsk_switch_closed <= 1'b0;
            end else begin
                pins.enable <= 1'b0;
                busy        <= 1'b0;
                step_r      <= '0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/test_rf_transmit_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module test_rf_transmit_sequencer;
    import rts_pkg::*;
    localparam int LOCK = 20;
    typedef struct packed {
        rts_pins_t    p;
        rts_rf_ctrl_t r;
    } rts_row_t;
    rts_row_t rows [8] = '{'{3'h0, 5'h00}, '{3'h4, 5'h1C}, '{3'h6, 5'h1E},
        '{3'h5, 5'h1D}, '{3'h7, 5'h1F}, '{3'h2, 5'h00}, '{3'h1, 5'h00}, '{3'h0, 5'h00}};
    logic         pclk = 1'b0;
    logic         link_clk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h0;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata, rd, t0;
    logic         pready, pslverr, locked, clk_out, busy, er;
    rts_rf_ctrl_t rf_ctrl;
    rts_pins_t    pins, mdl_pins;
    rts_pins_t    tb_pins = 3'h0;
    logic         use_mdl = 1'b0;
    logic         go = 1'b0;
    logic         fsk = 1'b0;
    logic         pa_q = 1'b0;
    logic         fl_q = 1'b0;
    int           mismatches = 0;
    int           n_compared = 0;
    int           pa_rise, fl_rise, early, n;

    always #25 pclk = ~pclk;
    always #24 link_clk = ~link_clk;
    assign pins = use_mdl ? mdl_pins : tb_pins;

    rts_transmit_sequencer #(.LOCK_CYC(LOCK)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .rf_ctrl(rf_ctrl), .locked(locked), .link_clk(link_clk), .clk_out(clk_out));
    rts_mcu_model #(.WAIT_CYC(4 * LOCK)) mcu (.pclk(pclk), .presetn(presetn), .go(go),
        .fsk(fsk), .data(4'hA), .pins(mdl_pins), .busy(busy));

    // amplifier before lock means the controller wait was broken
    always @(posedge pclk) begin
        pa_q <= rf_ctrl.pa_on;
        fl_q <= rf_ctrl.freq_low;
        if (use_mdl && rf_ctrl.pa_on && !pa_q) pa_rise++;
        if (use_mdl && rf_ctrl.freq_low && !fl_q) fl_rise++;
        if (use_mdl && rf_ctrl.pa_on && !locked) early++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdr(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        mismatches++;
        give_verdict();
    end

    initial begin
        cyc(6);
        presetn <= 1'b1;
        rdr(12'h000);
        check(rd, 32'h0);
        rdr(12'h004);
        check(rd, 32'h0000_4000);
        rdr(12'h010);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, 12'h010, 32'h1);
        check({31'h0, er}, 32'h1);
        rdr(12'h000);
        check(rd, 32'h0);
        $display("reset and map test done");
        for (int i = 0; i < 8; i++) begin
            tb_pins <= rows[i].p;
            cyc(4);
            check({27'h0, rf_ctrl}, {27'h0, rows[i].r});
        end
        $display("pin table test done");
        tb_pins <= 3'h4;
        cyc(LOCK + 1);
        check({31'h0, locked}, 32'h0);
        cyc(5);
        check({31'h0, locked}, 32'h1);
        rdr(12'h004);
        check(rd, 32'h0000_4026);
        n = 0;
        repeat (40) begin
            @(posedge link_clk);
            if (clk_out === 1'b1) n++;
        end
        check({31'h0, n > 10 && n < 30}, 32'h1);
        rdr(12'h00C);
        t0 = rd;
        cyc(200);
        rdr(12'h00C);
        check({31'h0, (rd - t0) >= 2 && (rd - t0) <= 4}, 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        cyc(4);
        check({26'h0, rf_ctrl, locked}, 32'h0);
        rdr(12'h000);
        check(rd, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        cyc(4);
        check({27'h0, rf_ctrl}, 32'h1C);
        tb_pins <= 3'h0;
        cyc(4);
        $display("lock and register test done");
        tb_pins <= 3'h4;
        cyc(8);
        presetn <= 1'b0;
        cyc(3);
        check({26'h0, rf_ctrl, clk_out}, 32'h0);
        presetn <= 1'b1;
        cyc(2);
        check({27'h0, rf_ctrl}, 32'h0);
        cyc(2);
        check({27'h0, rf_ctrl}, 32'h1C);
        rdr(12'h008);
        check({31'h0, rd >= 32'h1 && rd < 32'h14}, 32'h1);
        tb_pins <= 3'h0;
        cyc(4);
        $display("mid-run reset test done");
        use_mdl <= 1'b1;
        for (int f = 0; f < 2; f++) begin
            pa_rise = 0;
            fl_rise = 0;
            early = 0;
            fsk <= f[0];
            go <= 1'b1;
            cyc(1);
            go <= 1'b0;
            cyc(2);
            for (int k = 0; k < 400 && busy === 1'b1; k++) cyc(1);
            check({31'h0, busy}, 32'h0);
            cyc(4);
            check({27'h0, rf_ctrl}, 32'h0);
            check(early, 32'h0);
            check(pa_rise, f ? 32'h1 : 32'h2);
            check(fl_rise, f ? 32'h2 : 32'h0);
            $display("transmit test done");
        end
        give_verdict();
    end
endmodule
`default_nettype wire
